// *** dv/rffc_mac_tx_model.sv ***
// Behavioural MAC transmitter that takes pause requests.
// Assumes pauseReq on the system clock; gap sets the busy span.
`timescale 1ns/1ps
module rffc_mac_tx_model (
  input wire logic clock,
  input wire logic reset,
  input rffc_pkg::rffc_pause_t pauseReq,
  input wire logic [3:0] gap,
  output logic pauseAck,
  output logic [7:0] pauseCount,
  output logic [15:0] lastTime
);
  logic [3:0] waitCnt_ff;

  always_ff @(posedge clock) begin
    if (reset) begin
      pauseAck <= 1'b0;
      pauseCount <= 8'h00;
      lastTime <= 16'h0000;
      waitCnt_ff <= 4'h0;
    end else if (pauseReq.valid && pauseAck) begin
      pauseAck <= 1'b0;
      pauseCount <= pauseCount + 8'h01;
      lastTime <= pauseReq.pauseTime;
      waitCnt_ff <= gap;
    end else if (pauseReq.valid && waitCnt_ff != 4'h0) begin
      waitCnt_ff <= waitCnt_ff - 4'h1;
    end else begin
      pauseAck <= pauseReq.valid;
    end
  end
endmodule

// *** dv/tb_rffc_flow_ctrl.sv ***
// Self-checking bench for receive FIFO flow control.
// Assumes the MAC transmitter model in rffc_mac_tx_model.
`timescale 1ns/1ps
module tb_rffc_flow_ctrl;
  localparam int STEP = 20;
  logic clock, reset, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] wstrb, gap;
  logic [rffc_pkg::LEVEL_W-1:0] fifoLevel;
  rffc_pkg::rffc_rx_t rxEvent;
  logic fullDuplex, speed100, txEnable, pauseAck, jamAssert;
  rffc_pkg::rffc_pause_t pauseReq;
  logic [7:0] pauseCount;
  logic [15:0] lastTime, pt;
  int err_count, compares, seed, n;

  rffc_flow_ctrl #(.JAM_STEP_CYC(STEP)) u_dut (
    .clock(clock), .reset(reset),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .fifoLevel(fifoLevel), .rxEvent(rxEvent),
    .fullDuplex(fullDuplex), .speed100(speed100),
    .txEnable(txEnable), .pauseAck(pauseAck),
    .pauseReq(pauseReq), .jamAssert(jamAssert)
  );

  rffc_mac_tx_model u_mac (
    .clock(clock), .reset(reset), .pauseReq(pauseReq), .gap(gap),
    .pauseAck(pauseAck), .pauseCount(pauseCount), .lastTime(lastTime)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic final_report;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      #1;
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      resp = bresp;
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
  endtask

  task automatic axr(input logic [7:0] a);
    logic ta, tr;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      #1;
      ta = arvalid && arready;
      tr = rvalid;
      got = rdata;
      resp = rresp;
      @(posedge clock);
      if (ta) arvalid <= 1'b0;
    end
  endtask

  task automatic idle(input int c);
    gap <= 4'($random(seed));
    repeat (c) @(posedge clock);
  endtask

  // Pulse one receive event, count jam cycles, flip speed mid-jam
  task automatic jam(input logic [4:0] ev, output int cnt);
    logic s;
    s = speed100;
    rxEvent <= ev;
    @(posedge clock);
    rxEvent <= 5'h00;
    cnt = 0;
    for (int i = 0; i < 720; i++) begin
      #1;
      if (jamAssert === 1'b1) cnt++;
      @(posedge clock);
      if (i == 10) speed100 <= ~s;
      if (i == 20) speed100 <= s;
    end
  endtask

  function automatic int jamCyc(input logic [3:0] c, input logic f);
    int b;
    case (c)
      4'h0: b = 125;
      4'h1: b = 250;
      4'h2: b = 375;
      4'h3: b = 625;
      default: b = (int'(c) - 3) * STEP;
    endcase
    return f ? b : b + 55;
  endfunction

  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    final_report();
  end

  initial begin
    seed = 32'haede_a311;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    gap = 4'h0;
    fifoLevel = '0;
    rxEvent = 5'h00;
    {fullDuplex, speed100, txEnable} = 3'h7;
    reset = 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    axr(rffc_pkg::OFS_CFG);
    chk("cfg", 32'h0000_0000, got);
    axr(rffc_pkg::OFS_PAUSE);
    chk("pause", 32'h0000_0000, got);
    axr(rffc_pkg::OFS_STATUS);
    chk("status", 32'h0000_0038, got);
    axr(8'h0C);
    chk("rresp", rffc_pkg::RESP_SLVERR, resp);
    axw(8'h40, 32'h0000_0001);
    chk("bresp", rffc_pkg::RESP_SLVERR, resp);
    pt = 16'($random(seed)) | 16'h0001;
    axw(rffc_pkg::OFS_PAUSE, {16'h0000, pt});
    chk("bresp", rffc_pkg::RESP_OKAY, resp);
    wstrb <= 4'h1;
    axw(rffc_pkg::OFS_PAUSE, 32'hFFFF_FFFF);
    wstrb <= 4'hF;
    pt[7:0] = 8'hFF;
    axr(rffc_pkg::OFS_PAUSE);
    chk("pause", {16'h0000, pt}, got);
    axw(rffc_pkg::OFS_CFG, 32'h0010_0401);
    fifoLevel <= 14'h03FF;
    idle(40);
    chk("pauses", 0, pauseCount);
    fifoLevel <= 14'h0400;
    idle(40);
    chk("pauses", 1, pauseCount);
    chk("ptime", pt, lastTime);
    idle(40);
    chk("pauses", 1, pauseCount);
    fifoLevel <= 14'h0100;
    idle(40);
    chk("pauses", 1, pauseCount);
    fifoLevel <= 14'h00FF;
    idle(40);
    chk("pauses", 2, pauseCount);
    chk("ptime", 0, lastTime);
    fifoLevel <= 14'h0400;
    idle(40);
    chk("pauses", 3, pauseCount);
    fifoLevel <= 14'h0000;
    idle(40);
    chk("pauses", 4, pauseCount);
    axw(rffc_pkg::OFS_CFG, 32'h0010_040E);
    fifoLevel <= 14'h0400;
    idle(40);
    chk("pauses", 4, pauseCount);
    txEnable <= 1'b0;
    axw(rffc_pkg::OFS_CFG, 32'h0010_0401);
    idle(40);
    chk("pauses", 4, pauseCount);
    txEnable <= 1'b1;
    idle(40);
    chk("pauses", 5, pauseCount);
    chk("ptime", pt, lastTime);
    fullDuplex <= 1'b0;
    for (int k = 0; k < 32; k++) begin
      speed100 <= k[0];
      axw(rffc_pkg::OFS_CFG, {16'h0010, 8'h04, 4'(k >> 1), 4'h1});
      jam(5'h10, n);
      chk("jam", jamCyc(4'(k >> 1), k[0]), n);
    end
    speed100 <= 1'b1;
    fifoLevel <= 14'h03FF;
    jam(5'h10, n);
    chk("jam", 0, n);
    fifoLevel <= 14'h0400;
    axw(rffc_pkg::OFS_CFG, 32'h0010_0408);
    jam(5'h0C, n);
    chk("jam", 125, n);
    jam(5'h0A, n);
    chk("jam", 0, n);
    axw(rffc_pkg::OFS_CFG, 32'h0010_0401);
    txEnable <= 1'b0;
    jam(5'h10, n);
    chk("jam", 0, n);
    final_report();
  end
endmodule

// *** logic/rffc_flow_ctrl.sv ***
// Receive FIFO flow control with an AXI4-Lite register slave.
// Assumes MAC receive events and FIFO level on the same clock.
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module rffc_flow_ctrl #(
  parameter int JAM_STEP_CYC = rffc_pkg::JAM_STEP_CYC
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic [rffc_pkg::LEVEL_W-1:0] fifoLevel,
  input rffc_pkg::rffc_rx_t rxEvent,
  input wire logic fullDuplex,
  input wire logic speed100,
  input wire logic txEnable,
  input wire logic pauseAck,
  output rffc_pkg::rffc_pause_t pauseReq,
  output logic jamAssert
);
  localparam int LW = rffc_pkg::LEVEL_W;

  typedef struct packed {
    logic awDone;
    logic wDone;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [1:0] rResp;
    logic [31:0] rData;
    logic [31:0] cfg;
    logic [15:0] pauseTime;
    logic pauseSent;
  } rffc_main_t;

  localparam rffc_main_t ST_RESET = '{
    awDone: 1'b0,
    wDone: 1'b0,
    awAddr: 8'h00,
    wData: 32'h0000_0000,
    wStrb: 4'h0,
    bValid: 1'b0,
    bResp: rffc_pkg::RESP_OKAY,
    rValid: 1'b0,
    rResp: rffc_pkg::RESP_OKAY,
    rData: 32'h0000_0000,
    cfg: rffc_pkg::CFG_RESET,
    pauseTime: rffc_pkg::PAUSE_RESET,
    pauseSent: 1'b0
  };

  rffc_main_t st_ff;
  rffc_main_t nxt_st;

  logic anyTrig;
  logic multTrig;
  logic brdTrig;
  logic ownTrig;
  logic [7:0] hiThr;
  logic [7:0] loThr;
  logic [3:0] jamCode;
  logic highReached;
  logic belowLow;
  logic addrMatch;
  logic jamStart;
  logic push;
  logic [15:0] pushTime;
  logic jamActive;
  logic pausePending;
  logic [31:0] status;

  function automatic logic [LW-1:0] thrBytes(input logic [7:0] thr);
    return LW'({thr, 6'h00});
  endfunction

  function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign anyTrig = st_ff.cfg[rffc_pkg::CFG_ANY];
  assign multTrig = st_ff.cfg[rffc_pkg::CFG_MULT];
  assign brdTrig = st_ff.cfg[rffc_pkg::CFG_BRD];
  assign ownTrig = st_ff.cfg[rffc_pkg::CFG_OWN];
  assign hiThr = st_ff.cfg[rffc_pkg::CFG_HI_LSB +: 8];
  assign loThr = st_ff.cfg[rffc_pkg::CFG_LO_LSB +: 8];
  assign jamCode = st_ff.cfg[rffc_pkg::CFG_JAM_LSB +: 4];

  // Level compares
  assign highReached = fifoLevel >= thrBytes(hiThr);
  assign belowLow = fifoLevel < thrBytes(loThr);

  // Per-type match, ignored in any-frame mode
  assign addrMatch = (multTrig && rxEvent.multicast) ||
                     (brdTrig && rxEvent.broadcast) ||
                     (ownTrig && rxEvent.ownAddr);

  always_comb begin
    status = 32'h0000_0000;
    status[rffc_pkg::ST_JAM] = jamActive;
    status[rffc_pkg::ST_SENT] = st_ff.pauseSent;
    status[rffc_pkg::ST_PEND] = pausePending;
    status[rffc_pkg::ST_FULL] = fullDuplex;
    status[rffc_pkg::ST_FAST] = speed100;
    status[rffc_pkg::ST_TXEN] = txEnable;
    status[rffc_pkg::ST_LEVEL_LSB +: LW] = fifoLevel;
  end

  always_comb begin
    nxt_st = st_ff;
    jamStart = 1'b0;
    push = 1'b0;
    pushTime = 16'h0000;

    // Half duplex back pressure
    if (!fullDuplex && txEnable && highReached) begin
      if (anyTrig) begin
        jamStart = rxEvent.preamble;
      end else begin
        jamStart = rxEvent.addrValid && addrMatch;
      end
    end

    // Full duplex pause frames
    if (fullDuplex && txEnable && anyTrig) begin
      if (!st_ff.pauseSent && highReached) begin
        push = 1'b1;
        pushTime = st_ff.pauseTime;
        nxt_st.pauseSent = 1'b1;
      end else if (st_ff.pauseSent && belowLow) begin
        push = 1'b1;
        pushTime = 16'h0000;
        nxt_st.pauseSent = 1'b0;
      end
    end

    // Write channel
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.awDone = 1'b1;
      nxt_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.wDone = 1'b1;
      nxt_st.wData = s_axi_wdata;
      nxt_st.wStrb = s_axi_wstrb;
    end
    if (st_ff.bValid && s_axi_bready) begin
      nxt_st.bValid = 1'b0;
    end
    if (st_ff.awDone && st_ff.wDone && !st_ff.bValid) begin
      nxt_st.awDone = 1'b0;
      nxt_st.wDone = 1'b0;
      nxt_st.bValid = 1'b1;
      nxt_st.bResp = rffc_pkg::RESP_OKAY;
      case ({st_ff.awAddr[7:2], 2'b00})
        rffc_pkg::OFS_CFG: begin
          nxt_st.cfg = mergeStrb(st_ff.cfg, st_ff.wData, st_ff.wStrb) &
                       rffc_pkg::CFG_MASK;
        end
        rffc_pkg::OFS_PAUSE: begin
          nxt_st.pauseTime = 16'(mergeStrb({16'h0000, st_ff.pauseTime},
                                           st_ff.wData, st_ff.wStrb));
        end
        rffc_pkg::OFS_STATUS: begin
          nxt_st.bResp = rffc_pkg::RESP_OKAY;
        end
        default: begin
          nxt_st.bResp = rffc_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Read channel
    if (st_ff.rValid && s_axi_rready) begin
      nxt_st.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rValid = 1'b1;
      nxt_st.rResp = rffc_pkg::RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        rffc_pkg::OFS_CFG: begin
          nxt_st.rData = st_ff.cfg;
        end
        rffc_pkg::OFS_PAUSE: begin
          nxt_st.rData = {16'h0000, st_ff.pauseTime};
        end
        rffc_pkg::OFS_STATUS: begin
          nxt_st.rData = status;
        end
        default: begin
          nxt_st.rData = 32'h0000_0000;
          nxt_st.rResp = rffc_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = !st_ff.awDone && !st_ff.bValid;
  assign s_axi_wready = !st_ff.wDone && !st_ff.bValid;
  assign s_axi_bvalid = st_ff.bValid;
  assign s_axi_bresp = st_ff.bResp;
  assign s_axi_arready = !st_ff.rValid;
  assign s_axi_rvalid = st_ff.rValid;
  assign s_axi_rdata = st_ff.rData;
  assign s_axi_rresp = st_ff.rResp;

  rffc_jam_timer #(
    .STEP_CYC(JAM_STEP_CYC)
  ) jamTimer (
    .clock(clock),
    .reset(reset),
    .start(jamStart),
    .code(jamCode),
    .speed100(speed100),
    .txEnable(txEnable),
    .active(jamActive)
  );

  rffc_pause_queue pauseQueue (
    .clock(clock),
    .reset(reset),
    .push(push),
    .pushTime(pushTime),
    .txEnable(txEnable),
    .pauseAck(pauseAck),
    .pauseReq(pauseReq),
    .pending(pausePending)
  );

  assign jamAssert = jamActive;

  any_preamble_a: assert property (@(posedge clock) disable iff (reset)
    !fullDuplex && txEnable && anyTrig && highReached &&
      rxEvent.preamble && !jamActive |=> jamActive)
    else $error("Preamble at high level did not jam");
  any_override_a: assert property (@(posedge clock) disable iff (reset)
    anyTrig && !rxEvent.preamble |-> !jamStart)
    else $error("Type selection acted in any-frame mode");
  high_pause_a: assert property (@(posedge clock) disable iff (reset)
    fullDuplex && txEnable && anyTrig && highReached &&
      !st_ff.pauseSent |=> pausePending && st_ff.pauseSent &&
      pauseReq.pauseTime == $past(st_ff.pauseTime))
    else $error("High level did not queue pause");
  fd_needs_any_a: assert property (@(posedge clock) disable iff (reset)
    fullDuplex && !anyTrig |-> !push && !jamStart)
    else $error("Full-duplex flow control without any-frame");
  single_pause_a: assert property (@(posedge clock) disable iff (reset)
    push && !st_ff.pauseSent |=> st_ff.pauseSent && (!push || belowLow))
    else $error("Extra pause frame queued");
  zero_pause_a: assert property (@(posedge clock) disable iff (reset)
    push && pushTime == 16'h0000 && st_ff.pauseTime != 16'h0000 |->
      st_ff.pauseSent && belowLow)
    else $error("Zero pause without earlier pause");
  tx_off_a: assert property (@(posedge clock) disable iff (reset)
    !txEnable |-> !pauseReq.valid && !push && !jamStart)
    else $error("Pause offered with transmitter off");
  tx_off_jam_a: assert property (@(posedge clock) disable iff (reset)
    !txEnable |=> !jamAssert)
    else $error("Back pressure with transmitter off");
  thr_units_a: assert property (@(posedge clock) disable iff (reset)
    highReached == (fifoLevel[LW-1:rffc_pkg::THR_SHIFT] >= hiThr) &&
      belowLow == (fifoLevel[LW-1:rffc_pkg::THR_SHIFT] < loThr))
    else $error("Threshold not in 64-byte units");
endmodule

// *** logic/rffc_jam_timer.sv ***
// Back-pressure jam timer.
// Assumes start is a one-cycle pulse on the system clock.
`timescale 1ns/1ps
module rffc_jam_timer #(
  parameter int STEP_CYC = rffc_pkg::JAM_STEP_CYC
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic start,
  input wire logic [3:0] code,
  input wire logic speed100,
  input wire logic txEnable,
  output logic active
);
  localparam int CW = rffc_pkg::JAM_CNT_W;

  typedef struct packed {
    logic active;
    logic [CW-1:0] count;
  } rffc_jam_t;

  rffc_jam_t st_ff;
  rffc_jam_t nxt_st;
  logic [CW-1:0] loadCyc;

  function automatic logic [CW-1:0] jamCycles(input logic [3:0] c,
                                              input logic fast);
    int n;
    n = 0;
    case (c)
      4'h0: n = rffc_pkg::JAM0_CYC;
      4'h1: n = rffc_pkg::JAM1_CYC;
      4'h2: n = rffc_pkg::JAM2_CYC;
      4'h3: n = rffc_pkg::JAM3_CYC;
      default: n = STEP_CYC * (int'(c) - 3);
    endcase
    if (!fast) begin
      n = n + rffc_pkg::JAM_SLOW_CYC;
    end
    return CW'(n);
  endfunction

  always_comb begin
    nxt_st = st_ff;
    loadCyc = jamCycles(code, speed100);
    if (!txEnable) begin
      nxt_st.active = 1'b0;
      nxt_st.count = '0;
    end else if (st_ff.active) begin
      if (st_ff.count == '0) begin
        nxt_st.active = 1'b0;
      end else begin
        nxt_st.count = st_ff.count - 1'b1;
      end
    end else if (start) begin
      nxt_st.active = 1'b1;
      nxt_st.count = loadCyc - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign active = st_ff.active;

  jam_load_a: assert property (@(posedge clock) disable iff (reset)
    start && !active && txEnable |=>
      active && st_ff.count == $past(loadCyc) - 1'b1)
    else $error("Jam count not loaded from table");
  jam_hold_a: assert property (@(posedge clock) disable iff (reset)
    active && st_ff.count != '0 && txEnable |=> active)
    else $error("Jam ended early");
  slow_len_a: assert property (@(posedge clock) disable iff (reset)
    start && !active && txEnable && !speed100 && code == 4'h0 |=>
      st_ff.count == CW'(rffc_pkg::JAM0_CYC + rffc_pkg::JAM_SLOW_CYC - 1))
    else $error("Slow jam not fast length plus margin");
endmodule

// *** logic/rffc_pause_queue.sv ***
// Holds one pause request until the MAC transmitter takes it.
// Assumes the MAC raises pauseAck at its next transmit window.
`timescale 1ns/1ps
module rffc_pause_queue (
  input wire logic clock,
  input wire logic reset,
  input wire logic push,
  input wire logic [15:0] pushTime,
  input wire logic txEnable,
  input wire logic pauseAck,
  output rffc_pkg::rffc_pause_t pauseReq,
  output logic pending
);
  typedef struct packed {
    logic pending;
    logic [15:0] pauseTime;
  } rffc_pq_t;

  rffc_pq_t st_ff;
  rffc_pq_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (pauseReq.valid && pauseAck) begin
      nxt_st.pending = 1'b0;
    end
    if (push) begin
      nxt_st.pending = 1'b1;
      nxt_st.pauseTime = pushTime;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pauseReq.valid = st_ff.pending && txEnable;
  assign pauseReq.pauseTime = st_ff.pauseTime;
  assign pending = st_ff.pending;

  pause_hold_a: assert property (@(posedge clock) disable iff (reset)
    pauseReq.valid && !pauseAck |=> pending &&
      ($past(push) || pauseReq.pauseTime == $past(pauseReq.pauseTime)))
    else $error("Pause request dropped before taken");
endmodule

// *** logic/rffc_pkg.sv ***
// Shared constants and types for receive FIFO flow control.
// Assumes a 25 MHz system clock and a byte-count FIFO level.
package rffc_pkg;
  localparam int CLK_MHZ = 25;
  localparam int LEVEL_W = 14;
  localparam int JAM_CNT_W = 14;
  localparam int THR_SHIFT = 6;

  // Register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_PAUSE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // Configuration fields
  localparam int CFG_ANY = 0;
  localparam int CFG_OWN = 1;
  localparam int CFG_BRD = 2;
  localparam int CFG_MULT = 3;
  localparam int CFG_JAM_LSB = 4;
  localparam int CFG_LO_LSB = 8;
  localparam int CFG_HI_LSB = 16;
  localparam logic [31:0] CFG_MASK = 32'h00FF_FFFF;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [15:0] PAUSE_RESET = 16'h0000;

  // Status fields
  localparam int ST_JAM = 0;
  localparam int ST_SENT = 1;
  localparam int ST_PEND = 2;
  localparam int ST_FULL = 3;
  localparam int ST_FAST = 4;
  localparam int ST_TXEN = 5;
  localparam int ST_LEVEL_LSB = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Jam lengths in ns
  localparam int JAM0_NS = 5000;
  localparam int JAM1_NS = 10000;
  localparam int JAM2_NS = 15000;
  localparam int JAM3_NS = 25000;
  localparam int JAM_STEP_NS = 50000;
  localparam int JAM_SLOW_NS = 2200;

  function automatic int cycUp(input int ns);
    return (ns * CLK_MHZ + 999) / 1000;
  endfunction

  localparam int JAM0_CYC = cycUp(JAM0_NS);
  localparam int JAM1_CYC = cycUp(JAM1_NS);
  localparam int JAM2_CYC = cycUp(JAM2_NS);
  localparam int JAM3_CYC = cycUp(JAM3_NS);
  localparam int JAM_STEP_CYC = cycUp(JAM_STEP_NS);
  localparam int JAM_SLOW_CYC = cycUp(JAM_SLOW_NS);

  typedef struct packed {
    logic preamble;
    logic addrValid;
    logic multicast;
    logic broadcast;
    logic ownAddr;
  } rffc_rx_t;

  typedef struct packed {
    logic valid;
    logic [15:0] pauseTime;
  } rffc_pause_t;
endpackage
